//--- lssm_top.sv
// Purpose: Low-side supervisor mode and settling-delay control with a
//          classic Wishbone register slave and one level interrupt.
// Assumes: Single 200 MHz clock, synchronous active-high reset which also
//          stands for power-up clear.
// Notes:   Reproduces the device's documented weaknesses: a premature
//          settling expiry on a core level rise and a stuck wake-up.
//
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module lssm_top #(
    parameter int unsigned FULL_CYC   = lssm_pkg::FULL_SETTLE_CYC,
    parameter int unsigned NORMAL_CYC = lssm_pkg::NORMAL_SETTLE_CYC
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    output logic                       irq_o,
    output logic                       reset_req_o,
    output logic                       wake_slow_o,
    output lssm_pkg::lssm_sv_state_t   low_sv_state_o,
    output lssm_pkg::lssm_sv_state_t   low_mon_state_o,
    output lssm_pkg::lssm_sv_state_t   high_sv_state_o,
    output logic                       low_delay_flag_o,
    output logic                       high_delay_flag_o,
    output logic                       wake_stuck_o
);
    import lssm_pkg::*;

    lssm_ctrl_t     low_side_supervisor_control;
    lssm_ctrl_t     high_side_supervisor_control;
    logic [3:0]     power_unit_flag_register;
    logic [3:0]     irq_mask;
    lssm_power_t    power_mode;
    logic [1:0]     core_level;
    logic           core_pending;
    logic           wake_stuck;
    logic           wb_req;
    logic           wr_low;
    logic           wr_high;
    logic           wr_flags;
    logic           wr_mask;
    logic           wr_power;
    logic           low_busy;
    logic           low_done;
    logic           high_busy;
    logic           high_done;
    logic           deep;
    logic           was_deep;
    logic           entering_deep;
    logic           leaving_deep;
    logic           low_fast_or_off;
    logic           high_hazard;
    logic           core_raise;
    logic           premature;
    logic           early_entry;
    logic [3:0]     flag_set;
    logic [31:0]    next_rdata;
    lssm_power_t    next_mode;
    logic [1:0]     next_level;
    lssm_sv_state_t high_active_state;

    // Bus decode; a single registered ack keeps every access one wait state.
    assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_low   = wb_req && wb_we_i && wb_sel_i[0]
                      && wb_adr_i == LOW_CTRL_OFS;
    assign wr_high  = wb_req && wb_we_i && wb_sel_i[0]
                      && wb_adr_i == HIGH_CTRL_OFS;
    assign wr_flags = wb_req && wb_we_i && wb_sel_i[0]
                      && wb_adr_i == FLAGS_OFS;
    assign wr_mask  = wb_req && wb_we_i && wb_sel_i[0]
                      && wb_adr_i == MASK_OFS;
    assign wr_power = wb_req && wb_we_i && wb_sel_i[0]
                      && wb_adr_i == POWER_OFS;

    // Requested mode and core level from the power register write.
    assign next_mode  = lssm_power_t'(wb_dat_i[2:0]);
    assign next_level = wb_dat_i[5:4];

    // Ack and read data; unmapped addresses ack and read as zero.
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (wb_adr_i)
            LOW_CTRL_OFS:  next_rdata[5:0] = low_side_supervisor_control;
            HIGH_CTRL_OFS: next_rdata[5:0] = high_side_supervisor_control;
            FLAGS_OFS:     next_rdata[3:0] = power_unit_flag_register;
            MASK_OFS:      next_rdata[3:0] = irq_mask;
            POWER_OFS:     next_rdata[5:0] = {core_level, 1'b0, power_mode};
            STATUS_OFS:    next_rdata[7:0] = {wake_stuck, core_pending,
                                              high_busy, low_busy,
                                              low_sv_state_o,
                                              wake_slow_o, deep};
            default:       next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= (wb_req && !wb_we_i) ? next_rdata : 32'h0000_0000;
        end
    end

    // Control registers; reset doubles as power-up clear.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            low_side_supervisor_control  <= CTRL_RESET;
            high_side_supervisor_control <= CTRL_RESET;
            irq_mask                     <= 4'h0;
        end
        else
        begin
            if (wr_low)
                low_side_supervisor_control <= wb_dat_i[5:0];
            if (wr_high)
                high_side_supervisor_control <= wb_dat_i[5:0];
            if (wr_mask)
                irq_mask <= wb_dat_i[3:0];
        end
    end

    // Settling timers; full performance picks the short delay.
    lssm_settle_timer #(
        .FAST_CYC (FULL_CYC),
        .SLOW_CYC (NORMAL_CYC)
    ) u_low_timer (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (wr_low),
        .fast_i  (wb_dat_i[FULLP_BIT]),
        .busy_o  (low_busy),
        .done_o  (low_done)
    );

    lssm_settle_timer #(
        .FAST_CYC (FULL_CYC),
        .SLOW_CYC (NORMAL_CYC)
    ) u_high_timer (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (wr_high),
        .fast_i  (wb_dat_i[FULLP_BIT]),
        .busy_o  (high_busy),
        .done_o  (high_done)
    );

    assign low_delay_flag_o  = low_busy;
    assign high_delay_flag_o = high_busy;

    // Supervisor state decode for the current power mode.
    assign deep = power_mode == PM_DEEP2 || power_mode == PM_DEEP3
                  || power_mode == PM_DEEP4;

    lssm_mode_decode u_low_sv (
        .enable_i    (low_side_supervisor_control.enable),
        .lp_mode_i   (low_side_supervisor_control.lp_mode),
        .full_perf_i (low_side_supervisor_control.full_perf),
        .auto_i      (low_side_supervisor_control.auto_ctl),
        .deep_i      (deep),
        .state_o     (low_sv_state_o)
    );

    lssm_mode_decode u_low_mon (
        .enable_i    (low_side_supervisor_control.mon_en),
        .lp_mode_i   (1'b1),
        .full_perf_i (low_side_supervisor_control.mon_fp),
        .auto_i      (low_side_supervisor_control.auto_ctl),
        .deep_i      (deep),
        .state_o     (low_mon_state_o)
    );

    lssm_mode_decode u_high_sv (
        .enable_i    (high_side_supervisor_control.enable),
        .lp_mode_i   (high_side_supervisor_control.lp_mode),
        .full_perf_i (high_side_supervisor_control.full_perf),
        .auto_i      (high_side_supervisor_control.auto_ctl),
        .deep_i      (1'b0),
        .state_o     (high_active_state)
    );

    assign high_sv_state_o = deep ? (high_hazard ? SV_OFF
                                                 : high_active_state)
                                  : high_active_state;

    // Slow wake-up only when enabled in normal mode.
    assign wake_slow_o = low_side_supervisor_control.enable
                         && !low_side_supervisor_control.full_perf;

    // Low supervisor fast or off, or its monitor fast or off; either test is enough.
    assign low_fast_or_off = !wake_slow_o
        || !low_side_supervisor_control.mon_en
        || low_side_supervisor_control.mon_fp;

    // High side goes from normal in active to off in deep sleep.
    assign high_hazard = high_side_supervisor_control.enable
        && !high_side_supervisor_control.full_perf
        && (!high_side_supervisor_control.lp_mode
            || high_side_supervisor_control.auto_ctl);

    // Power mode and core level; a level rise waits on the low settling.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            power_mode   <= PM_ACTIVE;
            core_level   <= 2'h0;
            core_pending <= 1'b0;
            was_deep     <= 1'b0;
        end
        else
        begin
            was_deep <= deep;
            if (wr_power && !(wake_stuck && next_mode == PM_ACTIVE))
                power_mode <= (next_mode > PM_DEEP4) ? PM_ACTIVE
                                                     : next_mode;
            if (wr_power)
                core_level <= next_level;
            if (core_raise)
                core_pending <= 1'b1;
            else if (low_done)
                core_pending <= 1'b0;
        end
    end

    assign core_raise    = wr_power && next_level > core_level;
    assign entering_deep = deep && !was_deep;
    assign leaving_deep  = !deep && was_deep;

    // The short delay expires before the core reaches its new level.
    assign premature = core_raise && low_side_supervisor_control.enable
                       && low_side_supervisor_control.full_perf;

    // Early deep entry while either side is still settling.
    assign early_entry = entering_deep && (low_busy || high_busy);

    // Stuck wake-up latch; only reset (power-up clear) frees it.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wake_stuck <= 1'b0;
        else if (early_entry
                 || (entering_deep && low_fast_or_off && high_hazard))
            wake_stuck <= 1'b1;
    end

    assign wake_stuck_o = wake_stuck;
    assign reset_req_o  = power_unit_flag_register[RESET_REQ_BIT];

    // Sticky flags: write one to clear, a new event wins over the clear.
    assign flag_set = {premature, (entering_deep && wake_stuck)
                       || (leaving_deep && wake_stuck),
                       high_done, low_done};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            power_unit_flag_register <= FLAGS_RESET;
        else
            power_unit_flag_register <= flag_set
                | (power_unit_flag_register
                   & ~(wr_flags ? wb_dat_i[3:0] : 4'h0));
    end

    assign irq_o = |(power_unit_flag_register & irq_mask);

endmodule
`default_nettype wire

//--- lssm_pkg.sv
// Purpose: Shared constants and types for the low-side supervisor mode control.
// Assumes: 200 MHz system clock, classic Wishbone register access.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
package lssm_pkg;

    // Clock period and settling times.
    localparam int unsigned CLK_PERIOD_PS    = 5000;
    localparam int unsigned FULL_SETTLE_NS   = 2000;
    localparam int unsigned NORMAL_SETTLE_NS = 150000;
    localparam int unsigned FULL_SETTLE_CYC  =
        (FULL_SETTLE_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned NORMAL_SETTLE_CYC =
        (NORMAL_SETTLE_NS * 1000) / CLK_PERIOD_PS;

    // Register byte offsets.
    localparam logic [7:0] LOW_CTRL_OFS  = 8'h00;
    localparam logic [7:0] HIGH_CTRL_OFS = 8'h04;
    localparam logic [7:0] FLAGS_OFS     = 8'h08;
    localparam logic [7:0] MASK_OFS      = 8'h0C;
    localparam logic [7:0] POWER_OFS     = 8'h10;
    localparam logic [7:0] STATUS_OFS    = 8'h14;

    // Control field positions (same layout on both sides).
    localparam int unsigned ENABLE_BIT  = 0;
    localparam int unsigned LPMODE_BIT  = 1;
    localparam int unsigned FULLP_BIT   = 2;
    localparam int unsigned AUTO_BIT    = 3;
    localparam int unsigned MON_EN_BIT  = 4;
    localparam int unsigned MON_FP_BIT  = 5;
    localparam logic [5:0]  CTRL_RESET  = 6'h00;

    // Sticky flag positions.
    localparam int unsigned LOW_DLY_DONE_BIT  = 0;
    localparam int unsigned HIGH_DLY_DONE_BIT = 1;
    localparam int unsigned WAKE_FAIL_BIT     = 2;
    localparam int unsigned RESET_REQ_BIT     = 3;
    localparam logic [3:0]  FLAGS_RESET       = 4'h0;

    // Power modes: 0 active, 1..2 light sleep, 3..5 deep sleep.
    typedef enum logic [2:0] {
        PM_ACTIVE = 3'h0,
        PM_LIGHT0 = 3'h1,
        PM_LIGHT1 = 3'h2,
        PM_DEEP2  = 3'h3,
        PM_DEEP3  = 3'h4,
        PM_DEEP4  = 3'h5
    } lssm_power_t;

    // Supervisor operating state.
    typedef enum logic [1:0] {
        SV_OFF    = 2'h0,
        SV_NORMAL = 2'h1,
        SV_FULL   = 2'h2
    } lssm_sv_state_t;

    // One supervisor control register.
    typedef struct packed {
        logic mon_fp;
        logic mon_en;
        logic auto_ctl;
        logic full_perf;
        logic lp_mode;
        logic enable;
    } lssm_ctrl_t;

endpackage

//--- lssm_settle_timer.sv
// Purpose: Settling-delay timer for one supervisor side.
// Assumes: start is a one-cycle pulse on a control register write.
// Notes:   A new start restarts the count with the newly selected length.
`timescale 1ns/1ps
`default_nettype none
module lssm_settle_timer #(
    parameter int unsigned FAST_CYC = 400,
    parameter int unsigned SLOW_CYC = 30000
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic start_i,
    input  wire logic fast_i,
    output logic      busy_o,
    output logic      done_o
);
    import lssm_pkg::*;

    localparam int unsigned CW = $clog2(SLOW_CYC + 1);

    logic [CW-1:0] count;

    // Load on start, count down to zero; busy is the delay flag.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count  <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end
        else if (start_i)
        begin
            count  <= fast_i ? CW'(FAST_CYC - 1) : CW'(SLOW_CYC - 1);
            busy_o <= 1'b1;
            done_o <= 1'b0;
        end
        else if (busy_o && count == '0)
        begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
        end
        else
        begin
            count  <= busy_o ? count - CW'(1) : count;
            done_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- lssm_mode_decode.sv
// Purpose: Decodes a supervisor's operating state for the present power mode.
// Assumes: Control fields follow the shared control layout.
// Notes:   Pure combinational decode, used for supervisor and monitor.
`timescale 1ns/1ps
`default_nettype none
module lssm_mode_decode (
    input  wire logic                    enable_i,
    input  wire logic                    lp_mode_i,
    input  wire logic                    full_perf_i,
    input  wire logic                    auto_i,
    input  wire logic                    deep_i,
    output lssm_pkg::lssm_sv_state_t     state_o
);
    import lssm_pkg::*;

    lssm_sv_state_t active_state;

    // Active and light sleep state follows enable and full performance.
    always_comb
    begin
        if (!enable_i)
            active_state = SV_OFF;
        else if (full_perf_i)
            active_state = SV_FULL;
        else
            active_state = SV_NORMAL;
    end

    // Deep sleep: off unless enabled with lp_mode; then manual keeps the active state, automatic drops a step.
    always_comb
    begin
        if (!deep_i)
            state_o = active_state;
        else if (!enable_i || !lp_mode_i)
            state_o = SV_OFF;
        else if (!auto_i)
            state_o = active_state;
        else if (full_perf_i)
            state_o = SV_NORMAL;
        else
            state_o = SV_OFF;
    end
endmodule
`default_nettype wire

//--- lssm_top_chk.sv
// Purpose: Port-level assertions for the low-side supervisor mode control.
// Assumes: Bound to lssm_top with shortened settling counts (8 and 40).
// Notes:   The minimum-length check is written for a fast count of 8.
`timescale 1ns/1ps
`default_nettype none
module lssm_top_chk
    import lssm_pkg::*;
#(
    parameter int unsigned FULL_CYC   = 8,
    parameter int unsigned NORMAL_CYC = 40
) (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [7:0]      wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [31:0]     wb_dat_o,
    input  wire logic            wb_ack_o,
    input  wire logic            reset_req_o,
    input  wire logic            wake_slow_o,
    input  wire lssm_sv_state_t  low_sv_state_o,
    input  wire logic            low_delay_flag_o,
    input  wire logic            high_delay_flag_o,
    input  wire logic            wake_stuck_o
);
    // The flag drops at most NORMAL_CYC cycles after it rises; the ceiling allows one spare cycle, and any slow-length restart exceeds it.
    localparam int DLY_MAX = NORMAL_CYC + 1;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Bus handshake: one answer per taken request, one cycle wide.
    property p_ack_resp;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("no ack");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_dat_zero;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_dat_zero: assert property (p_dat_zero) else $error("read data idle");
    // Settling flags follow control writes on each side.
    property p_low_set;
        wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
            && wb_adr_i == LOW_CTRL_OFS |-> ##[1:2] low_delay_flag_o;
    endproperty
    a_low_set: assert property (p_low_set) else $error("low flag");
    property p_high_set;
        wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
            && wb_adr_i == HIGH_CTRL_OFS |-> ##[1:2] high_delay_flag_o;
    endproperty
    a_high_set: assert property (p_high_set) else $error("high flag");
    property p_dly_min;
        $rose(low_delay_flag_o) |-> low_delay_flag_o[*8];
    endproperty
    a_dly_min: assert property (p_dly_min) else $error("delay short");
    property p_dly_max;
        $rose(low_delay_flag_o) |-> ##[1:DLY_MAX] !low_delay_flag_o;
    endproperty
    a_dly_max: assert property (p_dly_max) else $error("delay long");
    // Full performance always means the fast wake-up path.
    property p_full_fast;
        low_sv_state_o == SV_FULL |-> !wake_slow_o;
    endproperty
    a_full_fast: assert property (p_full_fast) else $error("slow wake");
    property p_stuck_hold;
        wake_stuck_o |=> wake_stuck_o;
    endproperty
    a_stuck_hold: assert property (p_stuck_hold) else $error("stuck lost");
    property p_rst_clear;
        $fell(rst_i) |-> !wake_stuck_o && !reset_req_o;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("reset");
endmodule
bind lssm_top lssm_top_chk #(
    .FULL_CYC   (FULL_CYC),
    .NORMAL_CYC (NORMAL_CYC)
) u_lssm_top_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reset_req_o(reset_req_o),
    .wake_slow_o(wake_slow_o), .low_sv_state_o(low_sv_state_o),
    .low_delay_flag_o(low_delay_flag_o),
    .high_delay_flag_o(high_delay_flag_o), .wake_stuck_o(wake_stuck_o)
);
`default_nettype wire

//--- lssm_top_tb.sv
// Purpose: Self-checking bench for the low-side supervisor mode control.
// Assumes: Settling counts shortened to 8 and 40 cycles.
// Notes:   Bus requests change only right after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module lssm_top_tb;
    import lssm_pkg::*;
    localparam int unsigned FC    = 8;
    localparam int unsigned NC    = 40;
    localparam int          LIMIT = 30000;
    logic           clk_i = 1'b0;
    logic           rst_i = 1'b1;
    logic           wb_cyc_i = 1'b0;
    logic           wb_stb_i = 1'b0;
    logic           wb_we_i = 1'b0;
    logic [7:0]     wb_adr_i = 8'h00;
    logic [3:0]     wb_sel_i = 4'hF;
    logic [31:0]    wb_dat_i = 32'h0;
    logic [31:0]    wb_dat_o, q;
    logic           wb_ack_o, irq_o, reset_req_o, wake_slow_o, wake_stuck_o;
    logic           low_delay_flag_o, high_delay_flag_o;
    lssm_sv_state_t low_sv_state_o, low_mon_state_o, high_sv_state_o;
    int             err_count = 0;
    int             samples_checked = 0;
    int             cyc_cnt = 0;

    lssm_top #(.FULL_CYC(FC), .NORMAL_CYC(NC)) u_lssm_top (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq_o(irq_o), .reset_req_o(reset_req_o),
        .wake_slow_o(wake_slow_o), .low_sv_state_o(low_sv_state_o),
        .low_mon_state_o(low_mon_state_o), .high_sv_state_o(high_sv_state_o),
        .low_delay_flag_o(low_delay_flag_o),
        .high_delay_flag_o(high_delay_flag_o), .wake_stuck_o(wake_stuck_o)
    );

    // Clock at 200 MHz.
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic summarize();
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Hang guard, sized well above the expected run length.
    always @(posedge clk_i)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == LIMIT)
        begin
            err_count++;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("[ERR] %s exp %h got %h", nm, e, g);
            err_count++;
        end
    endtask

    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        chk("ack", 32'h1, {31'h0, wb_ack_o});
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    // Counts cycles that one settling flag stays high, bounded.
    task automatic count(input logic hi, output int n);
        n = 0;
        @(negedge clk_i);
        while ((hi ? high_delay_flag_o : low_delay_flag_o) === 1'b1 && n < 99)
        begin
            n++;
            @(negedge clk_i);
        end
    endtask

    task automatic wait_idle();
        int n;
        count(1'b0, n);
        count(1'b1, n);
    endtask

    task automatic t_reset_vals();
        wb(1'b0, LOW_CTRL_OFS, 32'h0);
        chk("low_ctrl", 32'h0, q);
        wb(1'b0, FLAGS_OFS, 32'h0);
        chk("flags", 32'h0, q);
        wb(1'b1, 8'h40, 32'hFF);
        wb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, q);
        chk("irq", 32'h0, {31'h0, irq_o});
    endtask

    task automatic t_settle();
        int n;
        wb(1'b1, LOW_CTRL_OFS, 32'h05);
        count(1'b0, n);
        // The first cycle of the flag passes while the bus task waits on ack.
        chk("fast_len", FC - 1, n);
        wb(1'b0, FLAGS_OFS, 32'h0);
        chk("done", 32'h1, q & 32'h1);
        wb(1'b1, LOW_CTRL_OFS, 32'h01);
        count(1'b0, n);
        chk("slow_len", NC - 1, n);
        wb(1'b1, HIGH_CTRL_OFS, 32'h00);
        count(1'b1, n);
        chk("high_len", NC - 1, n);
        wb(1'b1, FLAGS_OFS, 32'h0F);
    endtask

    function automatic lssm_sv_state_t exp_st(logic [3:0] c, logic deep);
        if (!c[0] || (deep && !c[1]))
            return SV_OFF;
        if (deep && c[3])
            return c[2] ? SV_NORMAL : SV_OFF;
        return c[2] ? SV_FULL : SV_NORMAL;
    endfunction

    // Every setting of the low four control bits in every power mode.
    task automatic t_decode();
        for (int c = 0; c < 16; c++)
        begin
            wb(1'b1, LOW_CTRL_OFS, 32'(c));
            wait_idle();
            for (int p = 0; p < 6; p++)
            begin
                wb(1'b1, POWER_OFS, 32'(p));
                @(negedge clk_i);
                chk("state", exp_st(4'(c), p > 2), low_sv_state_o);
                chk("slow", c[0] & ~c[2], wake_slow_o);
            end
            wb(1'b1, POWER_OFS, 32'h0);
        end
    endtask

    task automatic t_core();
        wb(1'b1, MASK_OFS, 32'h08);
        wb(1'b1, LOW_CTRL_OFS, 32'h01);
        wait_idle();
        wb(1'b1, POWER_OFS, 32'h10);
        wait_idle();
        chk("no_reset", 32'h0, reset_req_o);
        wb(1'b1, LOW_CTRL_OFS, 32'h05);
        wait_idle();
        wb(1'b1, POWER_OFS, 32'h20);
        repeat (3) @(negedge clk_i);
        chk("reset_req", 32'h1, reset_req_o);
        chk("irq_on", 32'h1, irq_o);
        wb(1'b1, MASK_OFS, 32'h0);
        @(negedge clk_i);
        chk("irq_masked", 32'h0, irq_o);
        wb(1'b1, MASK_OFS, 32'h08);
        wb(1'b1, FLAGS_OFS, 32'h08);
        @(negedge clk_i);
        chk("req_clear", 32'h0, reset_req_o);
        chk("irq_off", 32'h0, irq_o);
    endtask

    task automatic t_stuck();
        do_reset();
        wb(1'b1, LOW_CTRL_OFS, 32'h01);
        wb(1'b1, POWER_OFS, 32'h03);
        @(negedge clk_i);
        chk("stuck_busy", 32'h1, wake_stuck_o);
        wb(1'b1, POWER_OFS, 32'h00);
        wb(1'b0, STATUS_OFS, 32'h0);
        chk("stuck_stat", 32'h80, q & 32'h80);
        do_reset();
        @(negedge clk_i);
        chk("unstuck", 32'h0, wake_stuck_o);
        wb(1'b1, HIGH_CTRL_OFS, 32'h01);
        wb(1'b1, LOW_CTRL_OFS, 32'h35);
        wait_idle();
        chk("high_am", SV_NORMAL, high_sv_state_o);
        chk("mon_am", SV_FULL, low_mon_state_o);
        wb(1'b1, POWER_OFS, 32'h03);
        @(negedge clk_i);
        chk("stuck_hz", 32'h1, wake_stuck_o);
        chk("high_deep", SV_OFF, high_sv_state_o);
        chk("mon_deep", SV_FULL, low_mon_state_o);
        do_reset();
    endtask

    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_vals();
        t_settle();
        t_decode();
        t_core();
        t_stuck();
        summarize();
    end
endmodule
`default_nettype wire
